/* design/clock_power_pkg.sv */
// constants for the key-protected clock and power controller
package clock_power_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_POWER_KEY_FIRST = 32'hffff0404;
    localparam logic [31:0] ADDR_POWER_CONTROL = 32'hffff0408;
    localparam logic [31:0] ADDR_POWER_KEY_SECOND = 32'hffff040c;
    localparam logic [31:0] ADDR_CLOCK_KEY_FIRST = 32'hffff0410;
    localparam logic [31:0] ADDR_CLOCK_SOURCE_CONTROL = 32'hffff0414;
    localparam logic [31:0] ADDR_CLOCK_KEY_SECOND = 32'hffff0418;
    localparam logic [31:0] ADDR_PERIPH_KEY_FIRST = 32'hffff0434;
    localparam logic [31:0] ADDR_PERIPH_CLOCK_CONTROL = 32'hffff0438;
    localparam logic [31:0] ADDR_PERIPH_KEY_SECOND = 32'hffff043c;
    localparam logic [31:0] ADDR_STATUS = 32'hffff0440;
    // ------------------------------------------------------------
    // key codes and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CLOCK_KEY1 = 16'h00aa;
    localparam logic [15:0] CLOCK_KEY2 = 16'h0055;
    localparam logic [15:0] POWER_KEY1 = 16'h0001;
    localparam logic [15:0] POWER_KEY2 = 16'h00f4;
    localparam logic [15:0] PERIPH_KEY1 = 16'h0076;
    localparam logic [15:0] PERIPH_KEY2 = 16'h00b1;
    localparam logic [7:0] POWER_CONTROL_RST = 8'h03;
    localparam logic [7:0] CLOCK_SOURCE_RST = 8'h21;
    localparam logic [15:0] PERIPH_CLOCK_RST = 16'h0124;
    // ------------------------------------------------------------
    // field positions and field codes
    // ------------------------------------------------------------
    localparam int REF_INTERNAL_BIT = 5;
    localparam int PWM_ON_BIT = 11;
    localparam int SPI_ON_BIT = 8;
    localparam int I2C1_ON_BIT = 5;
    localparam int I2C0_ON_BIT = 2;
    localparam logic [1:0] CLKMODE_PLL = 2'h1;
    localparam logic [1:0] CLKMODE_EXT = 2'h3;
    localparam logic [2:0] PM_ACTIVE = 3'h0;
    localparam logic [2:0] PM_PAUSE = 3'h1;
    localparam logic [2:0] PM_NAP = 3'h2;
    localparam logic [2:0] PM_SLEEP = 3'h3;
    localparam logic [2:0] PM_STOP = 3'h4;
    localparam logic [2:0] CD_MAX = 3'h7;
    // ------------------------------------------------------------
    // start-up times
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int NAP_CD0_NS = 2600;
    localparam int NAP_CD7_NS = 247000;
    localparam int SLEEP_NS = 1580000;
    localparam int STOP_NS = 1700000;
    localparam int POWERUP_NS = 66000000;
    localparam int NAP_CD0_CYC = (NAP_CD0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NAP_CD7_CYC = (NAP_CD7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_CYC = (SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_CYC = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_ARMED = 3'b010,
        KEY_STAGED = 3'b100
    } key_state_e;
    typedef enum logic [3:0] {
        ST_POWERUP = 4'b0001,
        ST_ACTIVE = 4'b0010,
        ST_LOW = 4'b0100,
        ST_WAKE = 4'b1000
    } power_state_e;
endpackage

/* design/clock_power_mode_control.sv */
// key-protected core clock, power mode and peripheral clock controller
`timescale 1ns/1ps
module clock_power_mode_control #(
    parameter int SLEEP_WAKE_CYCLES = clock_power_pkg::SLEEP_CYC,
    parameter int STOP_WAKE_CYCLES = clock_power_pkg::STOP_CYC,
    parameter int POWERUP_CYCLES = clock_power_pkg::POWERUP_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [clock_power_pkg::ADDR_W-1:0] regAddr,
    input wire logic [clock_power_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [clock_power_pkg::DATA_W-1:0] regRdData,
    input wire logic [3:0] extInterruptInput,
    input wire logic wakeTimerIrq,
    input wire logic pllLocked,
    output logic coreClkEn,
    output logic periphRun,
    output logic pllPowerOn,
    output logic xtalTimerPowerOn,
    output logic [1:0] activeClockingMode,
    output logic activeRefInternal,
    output logic spiClkEn,
    output logic firstI2cClkEn,
    output logic secondI2cClkEn,
    output logic pwmClkEn,
    output logic pllIrq
);
    import clock_power_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] divMask(input logic [2:0] shift);
        divMask = 7'((8'h01 << shift) - 8'h01);
    endfunction

    function automatic logic [2:0] i2cShift(input logic [1:0] code);
        case (code)
            2'h0: i2cShift = 3'h0;
            2'h1: i2cShift = 3'h2;
            2'h2: i2cShift = 3'h3;
            default: i2cShift = 3'h5;
        endcase
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [3:0] irqMeta, irqSync;
    logic lockMeta, lockSync;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irqMeta <= 4'h0;
            irqSync <= 4'h0;
            lockMeta <= 1'b0;
            lockSync <= 1'b0;
        end else begin
            irqMeta <= extInterruptInput;
            irqSync <= irqMeta;
            lockMeta <= pllLocked;
            lockSync <= lockMeta;
        end
    end

    // ------------------------------------------------------------
    // key sequence trackers: 0 clock, 1 power, 2 peripheral
    // ------------------------------------------------------------
    logic [31:0] keyAddr1 [3];
    logic [31:0] valAddr [3];
    logic [31:0] keyAddr2 [3];
    logic [15:0] keyCode1 [3];
    logic [15:0] keyCode2 [3];
    assign keyAddr1 = '{ADDR_CLOCK_KEY_FIRST, ADDR_POWER_KEY_FIRST, ADDR_PERIPH_KEY_FIRST};
    assign valAddr = '{ADDR_CLOCK_SOURCE_CONTROL, ADDR_POWER_CONTROL,
        ADDR_PERIPH_CLOCK_CONTROL};
    assign keyAddr2 = '{ADDR_CLOCK_KEY_SECOND, ADDR_POWER_KEY_SECOND, ADDR_PERIPH_KEY_SECOND};
    assign keyCode1 = '{CLOCK_KEY1, POWER_KEY1, PERIPH_KEY1};
    assign keyCode2 = '{CLOCK_KEY2, POWER_KEY2, PERIPH_KEY2};

    key_state_e keyState [3];
    logic [15:0] staged [3];
    logic [2:0] commit;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_key
            // any write off the expected step drops back to idle, except a first-key write while staged, which re-arms
            // restart on deviation
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    keyState[g] <= KEY_IDLE;
                    staged[g] <= 16'h0000;
                end else if (regWr) begin
                    case (keyState[g])
                        KEY_ARMED: begin
                            if (regAddr == valAddr[g]) begin
                                keyState[g] <= KEY_STAGED;
                                staged[g] <= regWrData;
                            end else begin
                                keyState[g] <= KEY_IDLE;
                            end
                        end
                        default: begin
                            if (regAddr == keyAddr1[g] && regWrData == keyCode1[g]) begin
                                keyState[g] <= KEY_ARMED;
                            end else begin
                                keyState[g] <= KEY_IDLE;
                            end
                        end
                    endcase
                end
            end
            assign commit[g] = regWr && keyState[g] == KEY_STAGED &&
                regAddr == keyAddr2[g] && regWrData == keyCode2[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // protected registers
    // ------------------------------------------------------------
    logic [7:0] clockSourceControl;
    logic [7:0] powerControl;
    logic [15:0] periphClockControl;
    power_state_e state;
    logic wakeDone;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clockSourceControl <= CLOCK_SOURCE_RST;
            periphClockControl <= PERIPH_CLOCK_RST;
        end else begin
            if (commit[0]) begin
                clockSourceControl <= staged[0][7:0];
            end
            if (commit[2]) begin
                periphClockControl <= staged[2];
            end
        end
    end

    // mode field falls back to active once the wake-up completes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            powerControl <= POWER_CONTROL_RST;
        end else if (commit[1]) begin
            powerControl <= staged[1][7:0];
        end else if (wakeDone) begin
            powerControl[6:4] <= PM_ACTIVE;
        end
    end

    wire [2:0] pmField = powerControl[6:4];
    wire [2:0] cdField = powerControl[2:0];

    // ------------------------------------------------------------
    // power mode sequencer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] waitCnt;
    logic wakeEvent;
    logic lowMode;
    assign lowMode = pmField == PM_PAUSE || pmField == PM_NAP ||
        pmField == PM_SLEEP || pmField == PM_STOP;

    // stop ignores the timer, it is unpowered
    always_comb begin
        if (pmField == PM_STOP) begin
            wakeEvent = |irqSync;
        end else begin
            wakeEvent = (|irqSync) || wakeTimerIrq;
        end
    end

    // start-up counts per mode and divider
    function automatic logic [CNT_W-1:0] wakeCycles(input logic [2:0] pm, input logic [2:0] cd);
        if (pm == PM_SLEEP) begin
            wakeCycles = CNT_W'(SLEEP_WAKE_CYCLES);
        end else if (pm == PM_STOP) begin
            wakeCycles = CNT_W'(STOP_WAKE_CYCLES);
        end else if (cd == CD_MAX) begin
            wakeCycles = CNT_W'(NAP_CD7_CYC);
        end else begin
            wakeCycles = CNT_W'(NAP_CD0_CYC) << cd;
        end
    endfunction

    assign wakeDone = state == ST_WAKE && waitCnt == '0;

    // wake, wait start-up, back to active
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_POWERUP;
            waitCnt <= CNT_W'(POWERUP_CYCLES - 1);
        end else begin
            case (state)
                ST_POWERUP: begin
                    if (waitCnt == '0) begin
                        state <= ST_ACTIVE;
                    end else begin
                        waitCnt <= waitCnt - 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (lowMode) begin
                        state <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (wakeEvent) begin
                        state <= ST_WAKE;
                        waitCnt <= wakeCycles(pmField, cdField) - 1'b1;
                    end
                end
                ST_WAKE: begin
                    if (waitCnt == '0) begin
                        state <= ST_ACTIVE;
                    end else begin
                        waitCnt <= waitCnt - 1'b1;
                    end
                end
                default: begin
                    state <= ST_ACTIVE;
                end
            endcase
        end
    end

    // staged source takes over only after a nap wake
    logic fromNap;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fromNap <= 1'b0;
            activeClockingMode <= CLOCK_SOURCE_RST[1:0];
            activeRefInternal <= CLOCK_SOURCE_RST[REF_INTERNAL_BIT];
        end else begin
            if (state == ST_LOW && wakeEvent) begin
                fromNap <= pmField == PM_NAP;
            end
            // reserved mode codes are not applied
            if (wakeDone && fromNap) begin
                activeRefInternal <= clockSourceControl[REF_INTERNAL_BIT];
                if (clockSourceControl[1:0] == CLKMODE_PLL ||
                    clockSourceControl[1:0] == CLKMODE_EXT) begin
                    activeClockingMode <= clockSourceControl[1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // clock enables
    // ------------------------------------------------------------
    logic [6:0] divCnt;
    logic lockLost;
    logic coreHalt;
    logic periphOn;
    // unlocked pll stops the core while it feeds it
    assign coreHalt = activeClockingMode == CLKMODE_PLL && !lockSync;
    // peripherals run in active and pause only
    assign periphOn = state == ST_ACTIVE ||
        (state == ST_LOW && pmField == PM_PAUSE);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt <= 7'h00;
        end else begin
            divCnt <= divCnt + 7'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            coreClkEn <= 1'b0;
            periphRun <= 1'b0;
            pllPowerOn <= 1'b1;
            xtalTimerPowerOn <= 1'b1;
            spiClkEn <= 1'b0;
            firstI2cClkEn <= 1'b0;
            secondI2cClkEn <= 1'b0;
            pwmClkEn <= 1'b0;
        end else begin
            coreClkEn <= state == ST_ACTIVE && !coreHalt &&
                (divCnt & divMask(cdField)) == 7'h00;
            periphRun <= periphOn;
            // pll off in sleep and stop, crystal off in stop
            pllPowerOn <= !(state == ST_LOW && (pmField == PM_SLEEP || pmField == PM_STOP));
            xtalTimerPowerOn <= !(state == ST_LOW && pmField == PM_STOP);
            spiClkEn <= periphOn && periphClockControl[SPI_ON_BIT] &&
                (divCnt & divMask({1'b0, periphClockControl[7:6]})) == 7'h00;
            secondI2cClkEn <= periphOn && periphClockControl[I2C1_ON_BIT] &&
                (divCnt & divMask(i2cShift(periphClockControl[4:3]))) == 7'h00;
            firstI2cClkEn <= periphOn && periphClockControl[I2C0_ON_BIT] &&
                (divCnt & divMask(i2cShift(periphClockControl[1:0]))) == 7'h00;
            // pwm divider kept at 00, so undivided
            pwmClkEn <= periphOn && periphClockControl[PWM_ON_BIT];
        end
    end

    // interrupt only raised once lock is back
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lockLost <= 1'b0;
            pllIrq <= 1'b0;
        end else begin
            pllIrq <= lockLost && lockSync;
            if (!lockSync && state != ST_POWERUP) begin
                lockLost <= 1'b1;
            end else if (lockSync) begin
                lockLost <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                ADDR_POWER_CONTROL: regRdData <= {8'h00, powerControl};
                ADDR_CLOCK_SOURCE_CONTROL: regRdData <= {8'h00, clockSourceControl};
                ADDR_PERIPH_CLOCK_CONTROL: regRdData <= periphClockControl;
                ADDR_STATUS: regRdData <= {7'h00, lockSync, activeRefInternal,
                    activeClockingMode, 1'b0, state};
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_clock_key;
        @(posedge ref_clk) disable iff (!nrst)
        $changed(clockSourceControl) |-> $past(regWr && regAddr == ADDR_CLOCK_KEY_SECOND &&
            regWrData == CLOCK_KEY2);
    endproperty
    a_clock_key: assert property (p_clock_key) else $error("clock source changed without key");

    property p_power_key;
        @(posedge ref_clk) disable iff (!nrst)
        (regWr && regAddr == ADDR_POWER_CONTROL && keyState[1] != KEY_ARMED)
            |=> powerControl == $past(powerControl) || $past(wakeDone);
    endproperty
    a_power_key: assert property (p_power_key) else $error("unkeyed power write took");

    property p_periph_key;
        @(posedge ref_clk) disable iff (!nrst)
        $changed(periphClockControl) |-> $past(commit[2]) && $past(regWrData == PERIPH_KEY2);
    endproperty
    a_periph_key: assert property (p_periph_key) else $error("peripheral reg changed unkeyed");

    property p_stop_timer;
        @(posedge ref_clk) disable iff (!nrst)
        (state == ST_LOW && pmField == PM_STOP && irqSync == 4'h0) |=> state == ST_LOW;
    endproperty
    a_stop_timer: assert property (p_stop_timer) else $error("stop left without irq");

    property p_core_gate;
        @(posedge ref_clk) disable iff (!nrst)
        coreClkEn |-> $past(state == ST_ACTIVE);
    endproperty
    a_core_gate: assert property (p_core_gate) else $error("core clock outside active");

    property p_pll_halt;
        @(posedge ref_clk) disable iff (!nrst)
        coreHalt |=> !coreClkEn;
    endproperty
    a_pll_halt: assert property (p_pll_halt) else $error("core ran while pll unlocked");

    sequence s_wake_start;
        state == ST_LOW ##1 state == ST_WAKE && pmField == PM_PAUSE && cdField == 3'h0;
    endsequence
    property p_wake_time;
        @(posedge ref_clk) disable iff (!nrst)
        s_wake_start |-> ##25 state == ST_WAKE ##1 state == ST_ACTIVE;
    endproperty
    a_wake_time: assert property (p_wake_time) else $error("pause restart time wrong");

    property p_core_div;
        @(posedge ref_clk) disable iff (!nrst)
        (coreClkEn && cdField == 3'h1 && $stable(cdField)) |=> !coreClkEn;
    endproperty
    a_core_div: assert property (p_core_div) else $error("core divider by two broken");
endmodule

/* test/tb_clock_power_mode_control.sv */
// self-checking bench for the key-protected clock and power controller
`timescale 1ns/1ps
module tb_clock_power_mode_control;
    import clock_power_pkg::*;
    logic ref_clk, nrst, regWr, regRd, wakeTimerIrq, pllLocked;
    logic [31:0] regAddr;
    logic [15:0] regWrData, regRdData, rdv;
    logic [3:0] extInterruptInput;
    logic coreClkEn, periphRun, pllPowerOn, xtalTimerPowerOn, activeRefInternal;
    logic spiClkEn, firstI2cClkEn, secondI2cClkEn, pwmClkEn, pllIrq;
    logic [1:0] activeClockingMode;
    logic [4:0] en;
    int miscompares = 0;
    int num_checks = 0;
    int cnt;
    assign en = {pwmClkEn, secondI2cClkEn, firstI2cClkEn, spiClkEn, coreClkEn};
    // small start-up counts keep the run short
    clock_power_mode_control #(.SLEEP_WAKE_CYCLES(20), .STOP_WAKE_CYCLES(30),
        .POWERUP_CYCLES(10)) dut_u (.ref_clk, .nrst, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData, .extInterruptInput, .wakeTimerIrq, .pllLocked, .coreClkEn,
        .periphRun, .pllPowerOn, .xtalTimerPowerOn, .activeClockingMode,
        .activeRefInternal, .spiClkEn, .firstI2cClkEn, .secondI2cClkEn, .pwmClkEn,
        .pllIrq);
    // ------------------------------------------------------------
    // bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 rdv = regRdData;
    endtask
    // value register sits 4 above its first key, second key 8 above
    task automatic keyed(input logic [31:0] a, input logic [15:0] k1, v, k2);
        wr(a, k1);
        wr(a + 32'h4, v);
        wr(a + 32'h8, k2);
    endtask
    task automatic pulses(input int sel, input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1 cnt += (en[sel] === 1'b1);
        end
    endtask
    task automatic wait_core(input int lim);
        cnt = 0;
        while (coreClkEn !== 1'b1 && cnt < lim) begin
            @(posedge ref_clk);
            #1 cnt++;
        end
    endtask
    task automatic in_range(input int lo, input int hi);
        chk({15'h0, cnt >= lo && cnt <= hi}, 16'h1);
    endtask
    task automatic enter_low(input logic [15:0] v);
        keyed(ADDR_POWER_KEY_FIRST, POWER_KEY1, v, POWER_KEY2);
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(ADDR_POWER_CONTROL);
        chk(rdv, 16'h0003);
        rd(ADDR_CLOCK_SOURCE_CONTROL);
        chk(rdv, 16'h0021);
        rd(ADDR_PERIPH_CLOCK_CONTROL);
        chk(rdv, 16'h0124);
        rd(ADDR_CLOCK_KEY_FIRST);
        chk(rdv, 16'h0000);
        rd(32'hffff0500);
        chk(rdv, 16'h0000);
        chk({14'h0, activeClockingMode}, 16'h0001);
        pulses(0, 16);
        chk(cnt[15:0], 16'h2);
        pulses(4, 16);
        chk(cnt[15:0], 16'h0);
    endtask
    task automatic t_periph;
        keyed(ADDR_PERIPH_KEY_FIRST, PERIPH_KEY1, 16'h01e7, PERIPH_KEY2);
        rd(ADDR_PERIPH_CLOCK_CONTROL);
        chk(rdv, 16'h01e7);
        pulses(1, 64);
        chk(cnt[15:0], 16'h8);
        pulses(2, 64);
        chk(cnt[15:0], 16'h2);
        pulses(3, 64);
        chk(cnt[15:0], 16'h40);
        keyed(ADDR_PERIPH_KEY_FIRST, PERIPH_KEY1, 16'h0800, PERIPH_KEY2);
        pulses(4, 16);
        chk(cnt[15:0], 16'h10);
        for (int s = 1; s < 4; s++) begin
            pulses(s, 16);
            chk(cnt[15:0], 16'h0);
        end
        keyed(ADDR_PERIPH_KEY_FIRST, PERIPH_KEY1, 16'h0124, 16'h00b2);
        wr(ADDR_PERIPH_CLOCK_CONTROL, 16'h0124);
        rd(ADDR_PERIPH_CLOCK_CONTROL);
        chk(rdv, 16'h0800);
    endtask
    task automatic t_nap(input logic [15:0] cs, input logic [1:0] md, input logic ri);
        keyed(ADDR_CLOCK_KEY_FIRST, CLOCK_KEY1, cs, CLOCK_KEY2);
        rd(ADDR_CLOCK_SOURCE_CONTROL);
        chk(rdv, cs);
        enter_low(16'h0020);
        chk({periphRun, pllPowerOn}, 16'h1);
        @(posedge ref_clk) wakeTimerIrq <= 1'b1;
        wait_core(60);
        @(posedge ref_clk) wakeTimerIrq <= 1'b0;
        in_range(26, 40);
        chk({13'h0, activeClockingMode, activeRefInternal}, {13'h0, md, ri});
        rd(ADDR_POWER_CONTROL);
        chk(rdv, 16'h0000);
    endtask
    task automatic t_modes;
        keyed(ADDR_POWER_KEY_FIRST, POWER_KEY1, 16'h0007, POWER_KEY2);
        pulses(0, 256);
        chk(cnt[15:0], 16'h2);
        enter_low(16'h0010);
        @(posedge ref_clk) wakeTimerIrq <= 1'b1;
        wait_core(60);
        @(posedge ref_clk) wakeTimerIrq <= 1'b0;
        in_range(26, 40);
        // divider 7 keeps its 128-cycle phase, so the first core pulse may lag
        enter_low(16'h0017);
        pulses(0, 8);
        chk({cnt[14:0], periphRun}, 16'h1);
        @(posedge ref_clk) extInterruptInput <= 4'h1;
        wait_core(2700);
        @(posedge ref_clk) extInterruptInput <= 4'h0;
        in_range(2473, 2601);
        enter_low(16'h0030);
        chk({pllPowerOn, xtalTimerPowerOn}, 16'h1);
        @(posedge ref_clk) wakeTimerIrq <= 1'b1;
        wait_core(60);
        @(posedge ref_clk) wakeTimerIrq <= 1'b0;
        in_range(20, 40);
        enter_low(16'h0040);
        @(posedge ref_clk) wakeTimerIrq <= 1'b1;
        pulses(0, 60);
        chk({cnt[14:0], xtalTimerPowerOn}, 16'h0);
        @(posedge ref_clk) wakeTimerIrq <= 1'b0;
        extInterruptInput <= 4'h8;
        wait_core(80);
        @(posedge ref_clk) extInterruptInput <= 4'h0;
        in_range(30, 50);
        chk({15'h0, xtalTimerPowerOn}, 16'h1);
    endtask
    task automatic t_lock;
        @(posedge ref_clk) pllLocked <= 1'b0;
        repeat (4) @(posedge ref_clk);
        pulses(0, 16);
        chk(cnt[15:0], 16'h0);
        @(posedge ref_clk) pllLocked <= 1'b1;
        cnt = 0;
        repeat (10) begin
            @(posedge ref_clk);
            #1 cnt += (pllIrq === 1'b1);
        end
        chk(cnt[15:0], 16'h1);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #2000000;
        miscompares++;
        end_of_test();
    end
    initial begin
        nrst = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 32'h0;
        regWrData = 16'h0;
        wakeTimerIrq = 1'b0;
        pllLocked = 1'b1;
        extInterruptInput = 4'h0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        t_reset();
        t_periph();
        // end on the pll source so that lock loss can halt the core
        t_nap(16'h0023, 2'h3, 1'b1);
        t_nap(16'h0001, 2'h1, 1'b0);
        t_modes();
        t_lock();
        end_of_test();
    end
endmodule
